/* File: design/gauge_pkg.sv */
package gauge_pkg;

    // command codes of the read-only words
    localparam logic [7:0]  CMD_TEMP       = 8'h08;
    localparam logic [7:0]  CMD_VOLT       = 8'h09;
    localparam logic [7:0]  CMD_CURRENT    = 8'h0A;
    localparam logic [7:0]  CMD_MEAN_CUR   = 8'h0B;
    localparam logic [7:0]  CMD_ERR_MARGIN = 8'h0C;
    localparam logic [7:0]  CMD_REL_PCT    = 8'h0D;
    localparam logic [7:0]  CMD_ABS_PCT    = 8'h0E;
    localparam logic [7:0]  CMD_LEFT       = 8'h0F;

    // bus address of the gauge, plain default
    localparam logic [6:0]  SMB_ADDR_DEF   = 7'h0B;

    // uncertainty load values and limits in percent, and the last aging tally count
    localparam logic [6:0]  UNC_FULL       = 7'h64;
    localparam logic [6:0]  UNC_LEARN      = 7'h02;
    localparam logic [6:0]  UNC_CLIP       = 7'h08;
    localparam logic [6:0]  UNC_VCORR      = 7'h19;
    localparam logic [6:0]  UNC_MAX        = 7'h64;
    localparam logic [6:0]  UNC_MIN        = 7'h02;
    localparam logic [1:0]  TALLY_LAST     = 2'h3;

    // word clamps
    localparam logic [15:0] VOLT_MAX       = 16'h4E20;
    localparam logic [15:0] REL_MAX        = 16'h0064;

    // averaging: final shift of the rolling mean
    localparam int          AVG_SHIFT_DEF  = 6;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_CMD  = 3'b010,
        S_ACK  = 3'b011,
        S_TX   = 3'b100,
        S_MACK = 3'b101,
        S_WAIT = 3'b110
    } smb_st_e;

endpackage

/* File: design/soc_uncertainty_track.sv */
`timescale 1ns/1ps
module soc_uncertainty_track (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       full_reset,
    input  wire logic       learn_done,
    input  wire logic       learn_clipped,
    input  wire logic       tally_inc,
    input  wire logic       volt_correction,
    output logic      [6:0] soc_uncertainty_pct
);
    logic [6:0] unc_r;
    logic [6:0] unc_nxt;
    logic [1:0] tally_r;
    logic [1:0] tally_nxt;

    wire        fourth_inc = tally_inc && (tally_r == gauge_pkg::TALLY_LAST);
    wire  [6:0] clip_val   = (unc_r >= gauge_pkg::UNC_CLIP) ? gauge_pkg::UNC_CLIP : unc_r;
    wire  [6:0] bump_val   = (unc_r < gauge_pkg::UNC_MAX) ? unc_r + 7'h01 : unc_r;

    // full reset outranks a correction, which outranks learning and aging
    assign unc_nxt = full_reset      ? gauge_pkg::UNC_FULL :
                     volt_correction ? gauge_pkg::UNC_VCORR :
                     (learn_done && !learn_clipped) ? gauge_pkg::UNC_LEARN :
                     learn_done      ? clip_val :
                     fourth_inc      ? bump_val :
                     unc_r;
    // learning restarts the aging count
    assign tally_nxt = (full_reset || learn_done) ? 2'h0 :
                       tally_inc ? tally_r + 2'h1 : tally_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unc_r   <= gauge_pkg::UNC_FULL;
            tally_r <= 2'h0;
        end else begin
            unc_r   <= unc_nxt;
            tally_r <= tally_nxt;
        end
    end

    assign soc_uncertainty_pct = unc_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_unc_full_load: assert property (full_reset |=> unc_r == 7'h64)
        else $error("uncertainty not 100 after full reset");
    chk_unc_learn_two: assert property (learn_done && !learn_clipped && !volt_correction && !full_reset
        |=> unc_r == 7'h02) else $error("uncertainty not 2 after clean learning");
    chk_unc_clip_eight: assert property (learn_done && learn_clipped && !volt_correction && !full_reset
        |=> unc_r == (($past(unc_r) >= 7'h08) ? 7'h08 : $past(unc_r)))
        else $error("clipped learning load wrong");
    chk_unc_aging_step: assert property (tally_inc && tally_r == 2'h3 && !learn_done && !volt_correction
        && !full_reset && unc_r < 7'h64 |=> unc_r == $past(unc_r) + 7'h01)
        else $error("fourth tally step did not raise uncertainty");
    chk_unc_vcorr_load: assert property (volt_correction && !full_reset |=> unc_r == 7'h19)
        else $error("uncertainty not 25 after correction");
    chk_unc_range_keep: assert property (unc_r >= 7'h02 && unc_r <= 7'h64)
        else $error("uncertainty out of range");

    cov_unc_aging: cover property (fourth_inc && !learn_done && !full_reset && !volt_correction);
    cov_unc_clip:  cover property (learn_done && learn_clipped && unc_r >= 7'd8);

endmodule // soc_uncertainty_track

/* File: design/gauge_measurement_readout.sv */
`timescale 1ns/1ps
// What this block does
// - command 0x08 returns unsigned temperature in tenths of a kelvin
// - command 0x09 returns pack voltage in millivolts, valid up to 20000
// - command 0x0a returns signed instantaneous current, positive charging
// - command 0x0b returns signed one-minute rolling mean of current
// - the mean is meaningful from the very first sample
// - command 0x0c returns uncertainty percent kept between 2 and 100
// - full reset loads uncertainty with 100
// - unclipped learning cycle completion loads uncertainty with 2
// - clipped learning loads 8 when uncertainty is 8 or more, else keeps it
// - four tally steps without learning raise uncertainty by one
// - a voltage correction of the counter loads uncertainty with 25
// - command 0x0d returns percent of learned capacity, limited to 0..100
// - command 0x0e returns percent of nominal capacity, may exceed 100
// - command 0x0f returns charge left in mAh, or 10 mWh when units bit set
// - every value moves by a read-word transaction, low byte first
// - units-select bit of the pack setup word picks charge or energy units
module gauge_measurement_readout #(
    parameter logic [6:0] SMB_ADDR  = gauge_pkg::SMB_ADDR_DEF,
    parameter int         AVG_SHIFT = gauge_pkg::AVG_SHIFT_DEF
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    input  wire logic [15:0] temp_meas,
    input  wire logic [15:0] volt_meas,
    input  wire logic [15:0] cur_meas,
    input  wire logic        cur_valid,
    input  wire logic [15:0] rel_pct_meas,
    input  wire logic [15:0] abs_pct_meas,
    input  wire logic [15:0] charge_mah,
    input  wire logic [15:0] charge_mwh10,
    input  wire logic        units_select,
    input  wire logic        full_reset,
    input  wire logic        learn_done,
    input  wire logic        learn_clipped,
    input  wire logic        tally_inc,
    input  wire logic        volt_correction,
    output logic       [6:0] soc_uncertainty_pct
);
    if (AVG_SHIFT < 1 || AVG_SHIFT > 14) begin : g_shift_check
        $error("AVG_SHIFT must be 1..14");
    end

    // pin synchronisers, first stage read only by the second
    logic [1:0] scl_sy_r;
    logic [1:0] sda_sy_r;
    logic       scl_q_r;
    logic       sda_q_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sy_r <= 2'b11;
            sda_sy_r <= 2'b11;
            scl_q_r  <= 1'b1;
            sda_q_r  <= 1'b1;
        end else begin
            scl_sy_r <= {scl_sy_r[0], scl_i};
            sda_sy_r <= {sda_sy_r[0], sda_i};
            scl_q_r  <= scl_sy_r[1];
            sda_q_r  <= sda_sy_r[1];
        end
    end

    wire scl_s    = scl_sy_r[1];
    wire sda_s    = sda_sy_r[1];
    wire scl_rise = scl_s && !scl_q_r;
    wire scl_fall = !scl_s && scl_q_r;
    wire start_c  = scl_s && scl_q_r && sda_q_r && !sda_s;
    wire stop_c   = scl_s && scl_q_r && !sda_q_r && sda_s;

    // rolling mean, shift grows with sample count so early samples weigh more than later ones
    logic signed [15:0] avg_r;
    logic        [3:0]  k_r;
    logic        [15:0] n_r;

    wire signed [16:0] avg_diff = $signed({cur_meas[15], cur_meas}) - $signed({avg_r[15], avg_r});
    wire signed [16:0] avg_step = avg_diff >>> k_r;
    wire signed [16:0] avg_sum  = $signed({avg_r[15], avg_r}) + avg_step;
    wire        [15:0] n_mark   = (16'h0001 << (k_r + 4'h1)) - 16'h0001;
    wire               k_grow   = (k_r < 4'(AVG_SHIFT)) && (n_r == n_mark);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avg_r <= 16'sh0000;
            k_r   <= 4'h0;
            n_r   <= 16'h0000;
        end else if (cur_valid) begin
            avg_r <= avg_sum[15:0];
            k_r   <= k_grow ? k_r + 4'h1 : k_r;
            n_r   <= (n_r == 16'hFFFF) ? n_r : n_r + 16'h0001;
        end
    end

    soc_uncertainty_track u_unc (
        .clk                 (clk),
        .rst_n               (rst_n),
        .full_reset          (full_reset),
        .learn_done          (learn_done),
        .learn_clipped       (learn_clipped),
        .tally_inc           (tally_inc),
        .volt_correction     (volt_correction),
        .soc_uncertainty_pct (soc_uncertainty_pct)
    );

    // word selection by command code
    logic [7:0] cmd_r;

    wire [15:0] temp_w = temp_meas;
    wire [15:0] volt_w = (volt_meas > gauge_pkg::VOLT_MAX) ? gauge_pkg::VOLT_MAX : volt_meas;
    wire [15:0] cur_w  = cur_meas;
    wire [15:0] unc_w  = {9'h000, soc_uncertainty_pct};
    wire [15:0] rel_w  = (rel_pct_meas > gauge_pkg::REL_MAX) ? gauge_pkg::REL_MAX : rel_pct_meas;
    wire [15:0] abs_w  = abs_pct_meas;
    wire [15:0] left_w = units_select ? charge_mwh10 : charge_mah;
    wire [15:0] word_sel =
        (cmd_r == gauge_pkg::CMD_TEMP)       ? temp_w :
        (cmd_r == gauge_pkg::CMD_VOLT)       ? volt_w :
        (cmd_r == gauge_pkg::CMD_CURRENT)    ? cur_w :
        (cmd_r == gauge_pkg::CMD_MEAN_CUR)   ? avg_r :
        (cmd_r == gauge_pkg::CMD_ERR_MARGIN) ? unc_w :
        (cmd_r == gauge_pkg::CMD_REL_PCT)    ? rel_w :
        (cmd_r == gauge_pkg::CMD_ABS_PCT)    ? abs_w :
        left_w;

    // bus slave state
    gauge_pkg::smb_st_e st_r;
    gauge_pkg::smb_st_e st_nxt;
    gauge_pkg::smb_st_e after_r;
    gauge_pkg::smb_st_e after_nxt;
    logic [2:0]  bit_r;
    logic [2:0]  bit_nxt;
    logic [7:0]  sh_r;
    logic [7:0]  sh_nxt;
    logic [7:0]  tx_r;
    logic [7:0]  tx_nxt;
    logic [7:0]  cmd_nxt;
    logic        cmd_ok_r;
    logic        cmd_ok_nxt;
    logic [15:0] snap_r;
    logic [15:0] snap_nxt;
    logic        hi_r;
    logic        hi_nxt;
    logic        mack_r;
    logic        mack_nxt;
    logic        low_r;
    logic        low_nxt;

    wire [7:0] rx_byte  = {sh_r[6:0], sda_s};
    wire       byte_end = scl_rise && (bit_r == 3'h7);
    wire       addr_hit = (rx_byte[7:1] == SMB_ADDR);
    wire       rx_cmd_ok = (rx_byte >= gauge_pkg::CMD_TEMP) && (rx_byte <= gauge_pkg::CMD_LEFT);

    always_comb begin
        st_nxt     = st_r;
        after_nxt  = after_r;
        bit_nxt    = bit_r;
        sh_nxt     = sh_r;
        tx_nxt     = tx_r;
        cmd_nxt    = cmd_r;
        cmd_ok_nxt = cmd_ok_r;
        snap_nxt   = snap_r;
        hi_nxt     = hi_r;
        mack_nxt   = mack_r;
        low_nxt    = low_r;
        if (stop_c) begin
            st_nxt  = gauge_pkg::S_IDLE;
            low_nxt = 1'b0;
        end else if (start_c) begin
            st_nxt  = gauge_pkg::S_ADDR;
            bit_nxt = 3'h0;
            low_nxt = 1'b0;
        end else begin
            unique case (st_r)
                gauge_pkg::S_IDLE, gauge_pkg::S_WAIT: begin
                end
                gauge_pkg::S_ADDR: begin
                    if (scl_rise) begin
                        sh_nxt  = rx_byte;
                        bit_nxt = bit_r + 3'h1;
                    end
                    if (byte_end) begin
                        st_nxt = gauge_pkg::S_WAIT;
                        if (addr_hit && !rx_byte[0]) begin
                            st_nxt    = gauge_pkg::S_ACK;
                            after_nxt = gauge_pkg::S_CMD;
                        end else if (addr_hit && cmd_ok_r) begin
                            // whole word frozen before the first byte leaves
                            st_nxt    = gauge_pkg::S_ACK;
                            after_nxt = gauge_pkg::S_TX;
                            snap_nxt  = word_sel;
                            tx_nxt    = word_sel[7:0];
                            hi_nxt    = 1'b0;
                        end
                    end
                end
                gauge_pkg::S_CMD: begin
                    if (scl_rise) begin
                        sh_nxt  = rx_byte;
                        bit_nxt = bit_r + 3'h1;
                    end
                    if (byte_end) begin
                        cmd_ok_nxt = rx_cmd_ok;
                        cmd_nxt    = rx_byte;
                        // codes outside this bank are not acknowledged
                        st_nxt     = rx_cmd_ok ? gauge_pkg::S_ACK : gauge_pkg::S_WAIT;
                        after_nxt  = gauge_pkg::S_WAIT;
                    end
                end
                gauge_pkg::S_ACK: begin
                    if (scl_fall) begin
                        if (!low_r) begin
                            low_nxt = 1'b1;
                        end else begin
                            st_nxt  = after_r;
                            bit_nxt = 3'h0;
                            low_nxt = (after_r == gauge_pkg::S_TX) ? !tx_r[7] : 1'b0;
                        end
                    end
                end
                gauge_pkg::S_TX: begin
                    if (scl_fall) begin
                        if (bit_r == 3'h7) begin
                            low_nxt = 1'b0;
                            st_nxt  = gauge_pkg::S_MACK;
                        end else begin
                            bit_nxt = bit_r + 3'h1;
                            tx_nxt  = {tx_r[6:0], 1'b0};
                            low_nxt = !tx_r[6];
                        end
                    end
                end
                gauge_pkg::S_MACK: begin
                    if (scl_rise) begin
                        mack_nxt = !sda_s;
                    end
                    if (scl_fall) begin
                        // low byte first, then high byte of the same snapshot
                        if (mack_r && !hi_r) begin
                            hi_nxt  = 1'b1;
                            tx_nxt  = snap_r[15:8];
                            bit_nxt = 3'h0;
                            low_nxt = !snap_r[15];
                            st_nxt  = gauge_pkg::S_TX;
                        end else begin
                            st_nxt = gauge_pkg::S_WAIT;
                        end
                    end
                end
                default: begin
                    st_nxt  = gauge_pkg::S_IDLE;
                    low_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r     <= gauge_pkg::S_IDLE;
            after_r  <= gauge_pkg::S_IDLE;
            bit_r    <= 3'h0;
            sh_r     <= 8'h00;
            tx_r     <= 8'h00;
            cmd_r    <= 8'h00;
            cmd_ok_r <= 1'b0;
            snap_r   <= 16'h0000;
            hi_r     <= 1'b0;
            mack_r   <= 1'b0;
            low_r    <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            after_r  <= after_nxt;
            bit_r    <= bit_nxt;
            sh_r     <= sh_nxt;
            tx_r     <= tx_nxt;
            cmd_r    <= cmd_nxt;
            cmd_ok_r <= cmd_ok_nxt;
            snap_r   <= snap_nxt;
            hi_r     <= hi_nxt;
            mack_r   <= mack_nxt;
            low_r    <= low_nxt;
        end
    end

    // open drain: only ever pull low, no clock stretching
    assign sda_o  = 1'b0;
    assign sda_oe = low_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_volt_clamp_top: assert property (cmd_r == 8'h09 && volt_meas > 16'h4E20 |-> word_sel == 16'h4E20)
        else $error("voltage word not clamped");
    chk_rel_pct_limit: assert property (cmd_r == 8'h0D |-> word_sel <= 16'h0064 &&
        (rel_pct_meas > 16'h0064 || word_sel == rel_pct_meas)) else $error("relative percent wrong");
    chk_left_units_sel: assert property (cmd_r == 8'h0F |-> word_sel == (units_select ? charge_mwh10 : charge_mah))
        else $error("charge left units wrong");
    chk_mean_first_val: assert property (cur_valid && n_r == 16'h0000 |=> avg_r == $past(cur_meas))
        else $error("first mean sample not taken whole");
    chk_snap_hold_word: assert property (st_r == gauge_pkg::S_TX && $past(st_r) == gauge_pkg::S_TX |-> $stable(snap_r))
        else $error("snapshot changed during transfer");
    chk_cmd_bad_nack: assert property (st_r == gauge_pkg::S_CMD && byte_end && !rx_cmd_ok && !start_c && !stop_c
        |=> st_r == gauge_pkg::S_WAIT ##1 !sda_oe) else $error("unsupported command acknowledged");

    cov_word_done:  cover property (st_r == gauge_pkg::S_MACK && hi_r && scl_fall);
    cov_energy_rd:  cover property (st_r == gauge_pkg::S_TX && cmd_r == 8'h0F && units_select);
    cov_mean_rd:    cover property (st_r == gauge_pkg::S_TX && cmd_r == 8'h0B && hi_r);

endmodule // gauge_measurement_readout

/* File: verification/smb_host_model.sv */
`timescale 1ns/1ps
module smb_host_model #(
    parameter logic [6:0] ADDR = gauge_pkg::SMB_ADDR_DEF
) (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    // idle bus: clock high, data released to the pull-up
    initial begin
        scl = 1'h1;
        sda_pull = 1'h0;
    end

    task automatic hw(input int n);
        repeat (n) @(negedge clk);
    endtask

    // data only moves while clock is low, well inside the setup margin
    task automatic put_bit(input logic b);
        scl = 1'h0;
        hw(4);
        sda_pull = ~b;
        hw(4);
        scl = 1'h1;
        hw(8);
    endtask

    // sample late in the high phase, device answers 3 clk after the fall
    task automatic get_bit(output logic b);
        scl = 1'h0;
        sda_pull = 1'h0;
        hw(8);
        scl = 1'h1;
        hw(6);
        b = sda;
        hw(2);
    endtask

    task automatic start_cond();
        scl = 1'h0;
        hw(4);
        sda_pull = 1'h0;
        hw(4);
        scl = 1'h1;
        hw(8);
        sda_pull = 1'h1;
        hw(8);
    endtask

    task automatic stop_cond();
        scl = 1'h0;
        hw(4);
        sda_pull = 1'h1;
        hw(4);
        scl = 1'h1;
        hw(8);
        sda_pull = 1'h0;
        hw(8);
    endtask

    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(v[i]);
        get_bit(a);
        ack = ~a;
    endtask

    task automatic recv_byte(output logic [7:0] v, input logic ack);
        for (int i = 7; i >= 0; i--) get_bit(v[i]);
        put_bit(~ack);
    endtask

    // read word: addr+W, command, repeated start, addr+R, low then high byte
    task automatic read_word(input logic [7:0] cmd, output logic [15:0] data, output logic [2:0] acks);
        logic a1, a2, a3;
        data = 16'h0000;
        start_cond();
        send_byte({ADDR, 1'h0}, a1);
        send_byte(cmd, a2);
        start_cond();
        send_byte({ADDR, 1'h1}, a3);
        if (a3) begin
            recv_byte(data[7:0], 1'h1);
            recv_byte(data[15:8], 1'h0);
        end
        stop_cond();
        acks = {a1, a2, a3};
    endtask
endmodule // smb_host_model

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'h0;
    logic        rst_n;
    logic        scl, host_pull, sda_o, sda_oe, sda_wire;
    logic [15:0] temp_meas, volt_meas, cur_meas, rel_pct_meas, abs_pct_meas, charge_mah, charge_mwh10;
    logic        cur_valid, units_select, full_reset, learn_done, learn_clipped, tally_inc, volt_correction;
    logic [6:0]  soc_uncertainty_pct;
    logic [15:0] d;
    logic [2:0]  a;
    logic [15:0] exp_w [8];
    int          n_fail = 0;
    int          check_count = 0;
    int          cycles = 0;

    always #2 clk = ~clk;
    // open drain: anyone pulling wins, otherwise the pull-up
    assign sda_wire = (sda_oe ? sda_o : 1'h1) & ~host_pull;

    gauge_measurement_readout #(.AVG_SHIFT(2)) gauge_measurement_readout_i (
        .clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o), .sda_oe(sda_oe),
        .temp_meas(temp_meas), .volt_meas(volt_meas), .cur_meas(cur_meas), .cur_valid(cur_valid),
        .rel_pct_meas(rel_pct_meas), .abs_pct_meas(abs_pct_meas), .charge_mah(charge_mah),
        .charge_mwh10(charge_mwh10), .units_select(units_select), .full_reset(full_reset),
        .learn_done(learn_done), .learn_clipped(learn_clipped), .tally_inc(tally_inc),
        .volt_correction(volt_correction), .soc_uncertainty_pct(soc_uncertainty_pct));

    smb_host_model smb_host_model_i (.clk(clk), .sda(sda_wire), .scl(scl), .sda_pull(host_pull));

    task automatic end_sim();
        if (n_fail == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // k: 0 full reset, 1 learn done, 2 tally step, 3 voltage correction
    task automatic step(input int k, input logic clip, input int n, input logic [6:0] exp);
        repeat (n) begin
            full_reset = (k == 0);
            learn_done = (k == 1);
            learn_clipped = clip;
            tally_inc = (k == 2);
            volt_correction = (k == 3);
            @(negedge clk);
            {full_reset, learn_done, learn_clipped, tally_inc, volt_correction} = 5'h00;
            @(negedge clk);
        end
        chk({9'h000, soc_uncertainty_pct}, {9'h000, exp});
    endtask

    // ceiling well above the thirteen word reads of the run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        {cur_valid, units_select, full_reset, learn_done, learn_clipped, tally_inc, volt_correction} = 7'h00;
        temp_meas = 16'hFFFF;
        volt_meas = 16'h5000;
        cur_meas = 16'hFF38;
        rel_pct_meas = 16'h0096;
        abs_pct_meas = 16'h0096;
        charge_mah = 16'h1234;
        charge_mwh10 = 16'h0ABC;
        rst_n = 1'h0;
        repeat (20) @(negedge clk);
        rst_n = 1'h1;
        repeat (5) @(negedge clk);
        chk({9'h000, soc_uncertainty_pct}, 16'h0064);
        cur_valid = 1'h1;
        @(negedge clk);
        cur_valid = 1'h0;
        // first sample taken whole into the mean; over-range voltage and relative percent clamp
        exp_w = '{16'hFFFF, 16'h4E20, 16'hFF38, 16'hFF38, 16'h0064, 16'h0064, 16'h0096, 16'h1234};
        for (int i = 0; i < 8; i++) begin
            smb_host_model_i.read_word(8'h08 + 8'(i), d, a);
            chk({13'h0000, a}, 16'h0007);
            chk(d, exp_w[i]);
        end
        // measurement moves after capture, mid low byte; both bytes keep the captured word
        fork
            smb_host_model_i.read_word(8'h08, d, a);
            begin
                repeat (540) @(negedge clk);
                temp_meas = 16'h0000;
            end
        join
        chk(d, 16'hFFFF);
        // later samples blend in with a growing shift: 0, then 100 at half weight
        cur_meas = 16'h0000;
        cur_valid = 1'h1;
        @(negedge clk);
        cur_meas = 16'h0064;
        @(negedge clk);
        cur_valid = 1'h0;
        smb_host_model_i.read_word(8'h0B, d, a);
        chk(d, 16'h0032);
        units_select = 1'h1;
        smb_host_model_i.read_word(8'h0F, d, a);
        chk(d, 16'h0ABC);
        smb_host_model_i.read_word(8'h10, d, a);
        chk({13'h0000, a}, 16'h0004);
        step(2, 1'h0, 4, 7'h64);
        step(3, 1'h0, 1, 7'h19);
        step(1, 1'h1, 1, 7'h08);
        step(2, 1'h0, 3, 7'h08);
        step(2, 1'h0, 1, 7'h09);
        step(1, 1'h0, 1, 7'h02);
        step(1, 1'h1, 1, 7'h02);
        smb_host_model_i.read_word(8'h0C, d, a);
        chk(d, 16'h0002);
        step(2, 1'h0, 4, 7'h03);
        step(0, 1'h0, 1, 7'h64);
        end_sim();
    end
endmodule // tb_top
